// >>> hw/nspd_defs.vh
`ifndef NSPD_DEFS_VH
`define NSPD_DEFS_VH

// register offsets on the 3-bit register port
`define NSPD_OFF_IN_LOW 3'h0
`define NSPD_OFF_IN_HIGH 3'h1
`define NSPD_OFF_MAIN_CFG 3'h2
`define NSPD_OFF_AUX_CFG 3'h3
`define NSPD_OFF_STATUS 3'h4
`define NSPD_OFF_CODE_LOW 3'h5
`define NSPD_OFF_CODE_HIGH 3'h6

// main configuration fields
`define NSPD_ORDER_HI 7
`define NSPD_ORDER_LO 6
`define NSPD_RES_HI 5
`define NSPD_RES_LO 3
`define NSPD_EN_AMP 2
`define NSPD_EN_DAC 1
`define NSPD_FIN_HALF 0

// auxiliary configuration fields
`define NSPD_AUX_BAND 1
`define NSPD_AUX_POL 0

// status fields
`define NSPD_ST_RUN 0
`define NSPD_ST_PULSE 1
`define NSPD_ST_PHASE 2

// reset values
`define NSPD_RST_BYTE 8'h00
`define NSPD_RST_WORD 16'h0000
`define NSPD_RST_CODE 11'h000
`define NSPD_RST_ERR 20'sh00000

// shaper arithmetic
`define NSPD_SHIFT_BASE 4'hc
`define NSPD_CODE_FULL 20'sh007ff
`define NSPD_RES_TOP 3'h7
`define NSPD_ERR_POS 20'sh1ffff
`define NSPD_ERR_NEG (-20'sh20000)
`define NSPD_CNT_FULL 11'h7ff

`endif

// >>> hw/nspd_shaper.v
`timescale 1ns/10ps
`include "nspd_defs.vh"

module nspd_shaper (
    input wire clk,
    input wire sys_rst,
    input wire run,
    input wire step,
    input wire [1:0] order,
    input wire [2:0] res_code,
    input wire [15:0] word,
    output reg [10:0] code
);

reg signed [19:0] err1;
reg signed [19:0] err2;
reg signed [19:0] fb;
reg signed [19:0] sat;
reg signed [19:0] next_err;

wire [3:0] shift;
wire signed [19:0] wide_word;
wire signed [19:0] sum;
wire signed [19:0] quot;
wire signed [19:0] top;
wire signed [19:0] rebuilt;
wire signed [19:0] raw_err;

// only the upper m bits reach the pwm; the rest is carried as error
assign shift = `NSPD_SHIFT_BASE - {1'b0, res_code};
assign wide_word = {4'h0, word};
assign top = `NSPD_CODE_FULL >>> (`NSPD_RES_TOP - res_code);

always @* begin
    if (order[1]) begin
        fb = (err1 <<< 1) - err2;
    end else if (order[0]) begin
        fb = err1;
    end else begin
        fb = `NSPD_RST_ERR;
    end
end

assign sum = wide_word + fb;
assign quot = sum >>> shift;

// codes never leave 0..2^m-1, the lost part stays in the error
always @* begin
    if (quot < `NSPD_RST_ERR) begin
        sat = `NSPD_RST_ERR;
    end else if (quot > top) begin
        sat = top;
    end else begin
        sat = quot;
    end
end

assign rebuilt = sat <<< shift;
assign raw_err = sum - rebuilt;

// clamp keeps the loop bounded when the input sits at a rail
always @* begin
    if (raw_err > `NSPD_ERR_POS) begin
        next_err = `NSPD_ERR_POS;
    end else if (raw_err < `NSPD_ERR_NEG) begin
        next_err = `NSPD_ERR_NEG;
    end else begin
        next_err = raw_err;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        code <= `NSPD_RST_CODE;
        err1 <= `NSPD_RST_ERR;
        err2 <= `NSPD_RST_ERR;
    end else if (!run) begin
        code <= `NSPD_RST_CODE;
        err1 <= `NSPD_RST_ERR;
        err2 <= `NSPD_RST_ERR;
    end else if (step) begin
        code <= sat[10:0];
        if (order == 2'b00) begin
            err1 <= `NSPD_RST_ERR;
            err2 <= `NSPD_RST_ERR;
        end else begin
            err1 <= next_err;
            err2 <= err1;
        end
    end
end

endmodule // nspd_shaper

// >>> hw/nspd_top.v
`timescale 1ns/10ps
`include "nspd_defs.vh"

// Notes on behaviour
// - input word is 16 bits; narrower values are left-aligned with zero fill.
// - main config bits 7:6 pick shaper order: 00 none, 01 first, 1x second.
// - main config bits 5:3 pick pwm resolution m = 4 plus field.
// - pwm uses an m-bit counter; one period is 2^m modulator clocks.
// - active shaper turns the word into m-bit codes averaging to the input.
// - pwm code is the upper m bits of the shaped 16-bit word.
// - first order alternates adjacent codes around the input value.
// - second order may use non-adjacent codes with the same average.
// - second order saturates codes to 0..2^m-1, never negative.
// - both input bytes reach the converter only on a high byte write.
// - main config bit 1 enables converter, bit 2 enables amplifier.
// - main config bit 0 picks modulator clock: full or half rate.
// - aux config bit 0 flips pwm polarity: 0 active high, 1 active low.
// - system reset clears every converter register to zero.
// - order zero gives plain m-bit pwm with no shaping.
// - pwm rate is clock over one plus halving bit over 2^m.

module nspd_top (
    input wire clk,
    input wire sys_rst,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg pwm_out,
    output reg amp_enable,
    output reg amp_band_select
);

// software visible registers
reg [7:0] input_low_bits;
reg [7:0] input_high_bits;
reg [7:0] main_config;
reg [7:0] aux_config;

// word actually converted
reg [15:0] conv_word;

// modulator timing
reg half_phase;
reg [10:0] pulse_cnt;

// read path
reg [7:0] next_rdata;

// decoded fields
wire [1:0] shaper_order;
wire [2:0] pulse_resolution_code;
wire dac_run;
wire amp_run;
wire fin_half;
wire output_polarity_flip;
wire amplifier_band_select;

// write decode
wire wr_low;
wire wr_high;
wire wr_main;
wire wr_aux;

// modulator
wire mod_tick;
wire [10:0] cnt_max;
wire period_end;
wire period_step;
wire [10:0] cur_code;
wire pulse_active;
wire next_pwm;

// field extraction
assign shaper_order = main_config[`NSPD_ORDER_HI:`NSPD_ORDER_LO];
assign pulse_resolution_code = main_config[`NSPD_RES_HI:`NSPD_RES_LO];
assign dac_run = main_config[`NSPD_EN_DAC];
assign amp_run = main_config[`NSPD_EN_AMP];
assign fin_half = main_config[`NSPD_FIN_HALF];
assign output_polarity_flip = aux_config[`NSPD_AUX_POL];
assign amplifier_band_select = aux_config[`NSPD_AUX_BAND];

// register port decode
assign wr_low = reg_wr && (reg_addr == `NSPD_OFF_IN_LOW);
assign wr_high = reg_wr && (reg_addr == `NSPD_OFF_IN_HIGH);
assign wr_main = reg_wr && (reg_addr == `NSPD_OFF_MAIN_CFG);
assign wr_aux = reg_wr && (reg_addr == `NSPD_OFF_AUX_CFG);

// input byte registers
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        input_low_bits <= `NSPD_RST_BYTE;
    end else if (wr_low) begin
        input_low_bits <= reg_wdata;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        input_high_bits <= `NSPD_RST_BYTE;
    end else if (wr_high) begin
        input_high_bits <= reg_wdata;
    end
end

// the converted word only moves on a high byte write, so a low byte
// written alone waits; software must write low first
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        conv_word <= `NSPD_RST_WORD;
    end else if (wr_high) begin
        conv_word <= {reg_wdata, input_low_bits};
    end
end

// configuration registers
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        main_config <= `NSPD_RST_BYTE;
    end else if (wr_main) begin
        main_config <= reg_wdata;
    end
end

// unused upper aux bits are plain storage and read back as written
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        aux_config <= `NSPD_RST_BYTE;
    end else if (wr_aux) begin
        aux_config <= reg_wdata;
    end
end

// modulator clock: every clock, or every second clock when halved
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        half_phase <= 1'b0;
    end else if (!dac_run) begin
        half_phase <= 1'b0;
    end else begin
        half_phase <= ~half_phase;
    end
end

assign mod_tick = dac_run && (!fin_half || half_phase);

// counter wraps at 2^m-1, so one period is 2^m ticks
assign cnt_max = `NSPD_CNT_FULL >> (`NSPD_RES_TOP - pulse_resolution_code);
assign period_end = (pulse_cnt >= cnt_max);
assign period_step = mod_tick && period_end;

// >= guards against a resolution shrink mid period leaving the count above max
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        pulse_cnt <= `NSPD_RST_CODE;
    end else if (!dac_run) begin
        pulse_cnt <= `NSPD_RST_CODE;
    end else if (period_step) begin
        pulse_cnt <= `NSPD_RST_CODE;
    end else if (mod_tick) begin
        pulse_cnt <= pulse_cnt + 11'h001;
    end
end

// shaper loads its next code on the same edge the counter returns to zero
nspd_shaper u_shaper (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(dac_run),
    .step(period_step),
    .order(shaper_order),
    .res_code(pulse_resolution_code),
    .word(conv_word),
    .code(cur_code)
);

// high for code counts out of 2^m; a code of zero gives no pulse
assign pulse_active = dac_run && (pulse_cnt < cur_code);
assign next_pwm = pulse_active ^ output_polarity_flip;

// outputs are registered, so the pin lags the counter by one clock
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        pwm_out <= 1'b0;
    end else begin
        pwm_out <= next_pwm;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        amp_enable <= 1'b0;
        amp_band_select <= 1'b0;
    end else begin
        amp_enable <= amp_run;
        amp_band_select <= amplifier_band_select;
    end
end

// read mux; unmapped offset reads zero
always @* begin
    next_rdata = `NSPD_RST_BYTE;
    case (reg_addr)
        `NSPD_OFF_IN_LOW: begin
            next_rdata = input_low_bits;
        end
        `NSPD_OFF_IN_HIGH: begin
            next_rdata = input_high_bits;
        end
        `NSPD_OFF_MAIN_CFG: begin
            next_rdata = main_config;
        end
        `NSPD_OFF_AUX_CFG: begin
            next_rdata = aux_config;
        end
        `NSPD_OFF_STATUS: begin
            next_rdata[`NSPD_ST_RUN] = dac_run;
            next_rdata[`NSPD_ST_PULSE] = pulse_active;
            next_rdata[`NSPD_ST_PHASE] = period_end;
        end
        `NSPD_OFF_CODE_LOW: begin
            next_rdata = cur_code[7:0];
        end
        `NSPD_OFF_CODE_HIGH: begin
            next_rdata = {5'h00, cur_code[10:8]};
        end
        default: begin
            next_rdata = `NSPD_RST_BYTE;
        end
    endcase
end

// data stand only in the cycle after the read strobe
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        reg_rdata <= `NSPD_RST_BYTE;
    end else if (reg_rd) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= `NSPD_RST_BYTE;
    end
end

endmodule // nspd_top

// >>> sim/nspd_amp_model.sv
`timescale 1ns/10ps
module nspd_amp_model (
    input wire clk,
    input wire pwm_in,
    input wire amp_on,
    input wire wide_band,
    output reg [15:0] level
);
    wire [3:0] k = wide_band ? 4'h2 : 4'h6;
    initial level = 16'h0000;
    // crude rc stage; output collapses to ground when the amplifier is off
    always @(posedge clk) begin
        if (!amp_on) begin
            level <= 16'h0000;
        end else begin
            level <= level - (level >> k) + (pwm_in ? (16'hffff >> k) : 16'h0000);
        end
    end
endmodule // nspd_amp_model

// >>> sim/nspd_top_chk.sv
`timescale 1ns/10ps
module nspd_top_chk (
    input wire clk,
    input wire sys_rst,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire pwm_out,
    input wire amp_enable,
    input wire amp_band_select
);
    reg [7:0] mir [0:3];
    reg [15:0] gap, run;
    reg ok, act_d;
    reg [1:0] wr_d;
    wire act = pwm_out ^ mir[3][0];
    wire rise = act && !act_d;
    wire [15:0] per = (16'h0010 << mir[2][5:3]) << mir[2][0];
    wire cwr = reg_wr && reg_addr[2:1] == 2'b01;
    // config writes may cut a period, so timing checks pause around them
    wire hold = cwr || wr_d != 2'b00;
    wire [7:0] msel = mir[reg_addr[1:0]];
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mir[0] <= 8'h00;
            mir[1] <= 8'h00;
            mir[2] <= 8'h00;
            mir[3] <= 8'h00;
            gap <= 16'h0000;
            run <= 16'h0000;
            ok <= 1'b0;
            act_d <= 1'b0;
            wr_d <= 2'b00;
        end else begin
            if (reg_wr && !reg_addr[2]) mir[reg_addr[1:0]] <= reg_wdata;
            wr_d <= {wr_d[0], cwr};
            act_d <= act;
            gap <= rise ? 16'h0001 : gap + 16'h0001;
            run <= (act && !hold) ? run + 16'h0001 : 16'h0000;
            ok <= hold ? 1'b0 : (rise ? 1'b1 : ok);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_off;
        !mir[2][1] && $stable(mir[3][0]);
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    // register updates on the write edge, the output flop one clock later
    property p_copy(a, n, q);
        (reg_wr && reg_addr == a) |-> ##2 q == $past(reg_wdata[n], 2);
    endproperty
    a_cfg_read_back: assert property (reg_rd && !reg_addr[2] |=> reg_rdata == $past(msel))
        else $error("register read back differs");
    a_unmapped_zero: assert property (s_rd(3'h7) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_run: assert property (s_rd(3'h4) |=> reg_rdata[0] == $past(mir[2][1]))
        else $error("status enable bit wrong");
    a_amp_copy: assert property (p_copy(3'h2, 2, amp_enable))
        else $error("amplifier enable not following config");
    a_band_copy: assert property (p_copy(3'h3, 1, amp_band_select))
        else $error("band select not following config");
    a_off_idle: assert property (s_off [*3] |-> pwm_out == mir[3][0])
        else $error("output active while disabled");
    // a full-scale code at full rate leaves a single inactive clock per period
    a_pulse_len: assert property (run <= per - 16'h0001)
        else $error("pulse longer than a period allows");
    a_rise_period: assert property (rise && ok |-> gap % per == 16'h0000)
        else $error("pulse start off the period grid");
endmodule // nspd_top_chk

bind nspd_top nspd_top_chk u_nspd_top_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pwm_out(pwm_out),
    .amp_enable(amp_enable),
    .amp_band_select(amp_band_select)
);

// >>> sim/nspd_top_tb.sv
`timescale 1ns/10ps
module nspd_top_tb;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [2:0] reg_addr = 3'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire pwm_out, amp_enable, amp_band_select;
    wire [15:0] level;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer n;
    reg [7:0] d;
    always #12.5 clk = ~clk;
    nspd_top u_nspd_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pwm_out(pwm_out), .amp_enable(amp_enable), .amp_band_select(amp_band_select));
    nspd_amp_model u_nspd_amp_model (.clk(clk), .pwm_in(pwm_out), .amp_on(amp_enable),
        .wide_band(amp_band_select), .level(level));
    task close_out;
        begin
            if (miscompares == 0 && samples_checked > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            close_out;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
                miscompares = miscompares + 1;
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] v);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= v;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [2:0] a);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    // counts active-high samples; windows are whole periods so phase does not matter
    task cnt(input integer len);
        integer i;
        begin
            n = 0;
            for (i = 0; i < len; i = i + 1) begin
                @(posedge clk);
                #1 if (pwm_out === 1'b1) n = n + 1;
            end
        end
    endtask
    task t_reset;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rd(i[2:0]);
                chk(d, 8'h00);
            end
            rd(3'h7);
            chk(d, 8'h00);
        end
    endtask
    task t_plain;
        begin
            wr(3'h0, 8'h00);
            wr(3'h1, 8'h50);
            wr(3'h2, 8'h06);
            repeat (40) @(posedge clk);
            cnt(64);
            chk(n, 20);
            rd(3'h4);
            chk(d[0], 1'b1);
            rd(3'h5);
            chk(d, 8'h05);
            wr(3'h2, 8'h07);
            repeat (40) @(posedge clk);
            cnt(128);
            chk(n, 40);
            wr(3'h3, 8'h03);
            repeat (40) @(posedge clk);
            cnt(128);
            chk(n, 88);
            chk(level == 16'h0000, 0);
            wr(3'h2, 8'h00);
            repeat (4) @(posedge clk);
            cnt(32);
            chk(n, 32);
            rd(3'h5);
            chk(d, 8'h00);
            wr(3'h3, 8'h00);
            repeat (4) @(posedge clk);
            cnt(32);
            chk(n, 0);
            chk(level, 16'h0000);
            rd(3'h4);
            chk(d[0], 1'b0);
            wr(3'h0, 8'hff);
            wr(3'h1, 8'hff);
            wr(3'h2, 8'h02);
            repeat (40) @(posedge clk);
            cnt(64);
            chk(n, 60);
        end
    endtask
    task t_res;
        integer r;
        reg [15:0] e;
        begin
            wr(3'h0, 8'ha5);
            wr(3'h1, 8'ha5);
            for (r = 0; r < 8; r = r + 1) begin
                wr(3'h2, {2'b00, r[2:0], 3'b110});
                repeat ((32 << r) + 8) @(posedge clk);
                e = 16'ha5a5 >> (12 - r);
                rd(3'h5);
                chk(d, e[7:0]);
                rd(3'h6);
                chk(d, e[15:8]);
            end
        end
    endtask
    task t_atomic;
        begin
            wr(3'h0, 8'he0);
            wr(3'h1, 8'h12);
            repeat (4200) @(posedge clk);
            rd(3'h5);
            chk(d, 8'h97);
            wr(3'h0, 8'h00);
            repeat (4200) @(posedge clk);
            rd(3'h5);
            chk(d, 8'h97);
            wr(3'h1, 8'h12);
            repeat (4200) @(posedge clk);
            rd(3'h5);
            chk(d, 8'h90);
        end
    endtask
    task t_shaper;
        integer r, k, s, e;
        reg [1:0] o;
        reg [7:0] w;
        begin
            for (r = 0; r < 4; r = r + 1) begin
                case (r)
                    0: begin o = 2'b01; w = 8'h58; e = 44; end
                    1: begin o = 2'b01; w = 8'h54; e = 42; end
                    2: begin o = 2'b10; w = 8'h54; e = 42; end
                    default: begin o = 2'b11; w = 8'h04; e = 2; end
                endcase
                wr(3'h2, 8'h00);
                wr(3'h0, 8'h00);
                wr(3'h1, w);
                wr(3'h2, {o, 6'b000110});
                repeat (128) @(posedge clk);
                s = 0;
                // eight periods, so the second order pattern sums the same at any phase
                for (k = 0; k < 8; k = k + 1) begin
                    rd(3'h5);
                    s = s + d;
                    if (o == 2'b01) chk(d == 8'h05 || d == 8'h06, 1);
                    if (w == 8'h04) chk(d <= 8'h01, 1);
                    repeat (14) @(posedge clk);
                end
                chk(s[15:0], e[15:0]);
            end
        end
    endtask
    task t_rerst;
        begin
            wr(3'h0, 8'h3c);
            wr(3'h3, 8'h03);
            repeat (20) @(posedge clk);
            sys_rst <= 1'b1;
            repeat (3) @(posedge clk);
            sys_rst <= 1'b0;
            #1 chk(pwm_out, 1'b0);
            t_reset;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_plain;
        t_res;
        t_atomic;
        t_shaper;
        t_rerst;
        close_out;
    end
endmodule // nspd_top_tb
